/* File: ofs_status_bank.v */
// Overcurrent and open-load status bank with per-output driver gating.
// Flag registers are read-and-clear; writes to them are ignored.
// Retry off times come from parameters, not from registers.
// Assumes the serial control logic presents one-cycle access strobes on clk,
// and that detector inputs are asynchronous analog comparator levels.
`timescale 1ns/1ps
`default_nettype none
`include "ofs_map.vh"

module ofs_status_bank #(
    parameter [17:0] OL_FILTER_CYC   = `OFS_OL_FILTER_CYC,
    parameter [17:0] RETRY_LONG_CYC  = `OFS_RETRY_LONG_CYC,
    parameter [17:0] RETRY_SHORT_CYC = `OFS_RETRY_SHORT_CYC
) (
    input  wire        clk,
    input  wire        sys_rst,
    // Register access from the serial control logic
    input  wire        accStrobe,
    input  wire        accWrite,
    input  wire        accClear,
    input  wire [5:0]  accAddr,
    input  wire [15:0] accWrData,
    output reg  [15:0] rdData_q,
    output reg         rdValid_q,
    // Control register fields held elsewhere
    input  wire [15:0] recoveryEnable,
    input  wire        retryDutySel,
    input  wire [15:0] outEnable,
    // Analog detector levels
    input  wire [15:0] overcurrentDet,
    input  wire [15:0] underCurrentDet,
    input  wire        tempWarnDet,
    // Results
    output wire [15:0] driverOn,
    output reg         warnOpenSummary_q,
    output reg         globalErrorFlag_q
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    // Meta stages never feed logic; only the sync stages do
    reg  [15:0] ocMeta_q;
    reg  [15:0] ocSync_q;
    reg  [15:0] ulMeta_q;
    reg  [15:0] ulSync_q;
    reg         twMeta_q;
    reg         twSync_q;

    // Two stages each; only the second stage feeds logic
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ocMeta_q <= 16'h0000;
            ocSync_q <= 16'h0000;
        end
        else
        begin
            ocMeta_q <= overcurrentDet;
            ocSync_q <= ocMeta_q;
        end
    end

    // Undercurrent levels, same two-stage treatment
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ulMeta_q <= 16'h0000;
            ulSync_q <= 16'h0000;
        end
        else
        begin
            ulMeta_q <= underCurrentDet;
            ulSync_q <= ulMeta_q;
        end
    end

    // Temperature warning level
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            twMeta_q <= 1'b0;
            twSync_q <= 1'b0;
        end
        else
        begin
            twMeta_q <= tempWarnDet;
            twSync_q <= twMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decode

    // Writes to the flag registers fall through; both are read-only
    wire accRead   = accStrobe & ~accWrite;
    wire hitOc     = (accAddr == `OFS_ADDR_OVERCURRENT);
    wire hitOl     = (accAddr == `OFS_ADDR_OPEN_LOAD);
    wire hitCfg    = (accAddr == `OFS_ADDR_CONFIG);
    // Clear rides on a read so the host always sees what it wipes
    wire clearOc   = accRead & accClear & hitOc;
    wire clearOl   = accRead & accClear & hitOl;
    // Config writes land whole; bits outside 6..3 are dropped
    wire cfgWrite  = accStrobe & accWrite & hitCfg;

    ////////////////////////////////////////////////////////////////////////
    // Configuration register, mask bits 6..3

    // Only the four mask bits are stored in this bank
    reg  [3:0]  cfgMask_q;

    // Bits outside 6..3 belong to other blocks and read zero here
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cfgMask_q <= `OFS_CONFIG_RESET;
        else if (cfgWrite)
            cfgMask_q <= accWrData[`OFS_CFG_GROUP_MASK:`OFS_CFG_SUMMARY_MASK];
    end

    wire maskGroup = cfgMask_q[`OFS_CFG_GROUP_MASK - `OFS_CFG_SUMMARY_MASK];
    wire maskB1Hs  = cfgMask_q[`OFS_CFG_BRIDGE1_HS - `OFS_CFG_SUMMARY_MASK];
    wire maskB1Ls  = cfgMask_q[`OFS_CFG_BRIDGE1_LS - `OFS_CFG_SUMMARY_MASK];
    wire maskSum   = cfgMask_q[0];

    // Per-stage open-load mask vector
    // Stages outside the three mask groups are never masked
    reg  [15:0] olMask;

    always @*
    begin
        olMask = 16'h0000;
        olMask[`OFS_BIT_BRIDGE1_HS]     = maskB1Hs;
        olMask[`OFS_BIT_BRIDGE1_LS]     = maskB1Ls;
        olMask[`OFS_BIT_FAST_DISCHARGE] = maskGroup;
        olMask[`OFS_BIT_GLASS_VOLTAGE]  = maskGroup;
        olMask[`OFS_BIT_OUTPUT_SEVEN]   = maskGroup;
    end

    // Off time per retry sets the duty of the pulsed current
    // Limitation: one duty select is shared by every stage
    wire [17:0] retryOff = retryDutySel ? RETRY_SHORT_CYC : RETRY_LONG_CYC;

    ////////////////////////////////////////////////////////////////////////
    // Per-stage fault logic

    wire [15:0] ocFlags;
    wire [15:0] olFlags;

    // One slice per status bit, bit i of both flag registers
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : gStage
            // Counters are 18 bits, enough for the 2 ms filter at 125 MHz
            reg         drv_q;
            reg         ocFlag_q;
            reg         olFlag_q;
            reg  [17:0] retryCnt_q;
            reg  [17:0] olCnt_q;

            // Overcurrent only counts while we actually drive the stage
            // Trade-off: a fault shorter than one clock may slip past
            wire ocHit   = ocSync_q[i] & drv_q;
            wire retryOn = (retryCnt_q != 18'h00000);
            // Open load watched only on an activated, conducting stage
            wire olWatch = drv_q & outEnable[i] & ulSync_q[i];
            // Counter parks at its end value while the fault persists
            wire olDone  = (olCnt_q == OL_FILTER_CYC - 18'h00001);

            // Driver gate: fault off, retry wait, or host-held off
            // Manual mode waits for the clear to land before restart
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    drv_q <= 1'b0;
                else if (ocHit)
                    drv_q <= 1'b0;
                else if (retryOn)
                    drv_q <= 1'b0;
                else if (recoveryEnable[i])
                    drv_q <= outEnable[i];
                else
                    drv_q <= outEnable[i] & ~ocFlag_q;
            end

            // Retry hold-off, loaded only in automatic recovery mode
            // Driver stays off for the whole count, then follows its request
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    retryCnt_q <= 18'h00000;
                else if (ocHit & recoveryEnable[i])
                    retryCnt_q <= retryOff;
                else if (retryOn)
                    retryCnt_q <= retryCnt_q - 18'h00001;
            end

            // Sticky flag; a new fault beats a clear in the same cycle
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    ocFlag_q <= 1'b0;
                else if (ocHit)
                    ocFlag_q <= 1'b1;
                else if (clearOc)
                    ocFlag_q <= 1'b0;
            end

            // Continuous undercurrent filter; any break restarts it
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    olCnt_q <= 18'h00000;
                else if (!olWatch)
                    olCnt_q <= 18'h00000;
                else if (!olDone)
                    olCnt_q <= olCnt_q + 18'h00001;
            end

            // Open-load flag, set wins over clear
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    olFlag_q <= 1'b0;
                else if (olWatch & olDone)
                    olFlag_q <= 1'b1;
                else if (clearOl)
                    olFlag_q <= 1'b0;
            end

            // Flatten per-stage state into the bank vectors
            assign driverOn[i] = drv_q;
            assign ocFlags[i]  = ocFlag_q;
            assign olFlags[i]  = olFlag_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read path

    reg  [15:0] rdMux;

    // Value returned is the flag state before any clear in this access
    // Config reads return only the bits this bank owns
    always @*
    begin
        rdMux = 16'h0000;
        if (hitOc)
            rdMux = ocFlags;
        else if (hitOl)
            rdMux = olFlags;
        else if (hitCfg)
            rdMux = {9'h000, cfgMask_q, 3'h0};
    end

    // Valid pulses for one cycle after each read strobe
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdValid_q <= 1'b0;
        else
            rdValid_q <= accRead;
    end

    // Unmapped addresses answer zero rather than stale data
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdData_q <= `OFS_FLAGS_RESET;
        else if (accRead)
            rdData_q <= rdMux;
    end

    ////////////////////////////////////////////////////////////////////////
    // Summary bits

    // Masks act only on the summary; the flags still latch
    wire olSummary  = |(olFlags & ~olMask);
    wire warnOrOpen = twSync_q | olSummary;

    // Registered so the global status byte sees clean levels
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            warnOpenSummary_q <= 1'b0;
        else
            warnOpenSummary_q <= warnOrOpen;
    end

    // Config bit 3 keeps warnings out of the global error flag
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            globalErrorFlag_q <= 1'b0;
        else
            globalErrorFlag_q <= warnOrOpen & ~maskSum;
    end

endmodule // ofs_status_bank

`default_nettype wire

/* File: ofs_map.vh */
// Constants for the output fault status bank: addresses, field positions,
// reset values and timing counts.
// Assumes a 125 MHz system clock and the device's serial control logic in front.
`ifndef OFS_MAP_VH
`define OFS_MAP_VH

// Register addresses on the serial control port
`define OFS_ADDR_OVERCURRENT   6'h11
`define OFS_ADDR_OPEN_LOAD     6'h12
`define OFS_ADDR_CONFIG        6'h3f

// Reset values
`define OFS_FLAGS_RESET        16'h0000
`define OFS_CONFIG_RESET       4'h0

// Configuration register field positions
`define OFS_CFG_SUMMARY_MASK   3
`define OFS_CFG_BRIDGE1_LS     4
`define OFS_CFG_BRIDGE1_HS     5
`define OFS_CFG_GROUP_MASK     6

// Flag bit positions shared by both flag registers
`define OFS_BIT_FAST_DISCHARGE 15
`define OFS_BIT_GLASS_VOLTAGE  14
`define OFS_BIT_OUTPUT_SEVEN   11
`define OFS_BIT_BRIDGE1_HS     1
`define OFS_BIT_BRIDGE1_LS     0

// Timing: figures in microseconds; counts are time times clock rate,
// sized to the 18-bit counters so no parameter is truncated
`define OFS_CLK_MHZ            125
`define OFS_OL_FILTER_TIME_US  2000
`define OFS_RETRY_LONG_TIME_US 1000
`define OFS_RETRY_SHORT_TIME_US 250
`define OFS_OL_FILTER_CYC      18'h3d090
`define OFS_RETRY_LONG_CYC     18'h1e848
`define OFS_RETRY_SHORT_CYC    18'h07a12

`endif

/* File: ofs_status_bank_sva.sv */
// Port checker for the status bank, bound onto the design.
// Assumes one clock and the asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module ofs_status_bank_sva #(
    parameter [17:0] OL_FILTER_CYC   = 18'd20,
    parameter [17:0] RETRY_LONG_CYC  = 18'd10,
    parameter [17:0] RETRY_SHORT_CYC = 18'd4
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        accStrobe,
    input wire logic        accWrite,
    input wire logic        accClear,
    input wire logic [5:0]  accAddr,
    input wire logic [15:0] accWrData,
    input wire logic [15:0] rdData_q,
    input wire logic        rdValid_q,
    input wire logic [15:0] recoveryEnable,
    input wire logic        retryDutySel,
    input wire logic [15:0] outEnable,
    input wire logic [15:0] overcurrentDet,
    input wire logic [15:0] underCurrentDet,
    input wire logic        tempWarnDet,
    input wire logic [15:0] driverOn,
    input wire logic        warnOpenSummary_q,
    input wire logic        globalErrorFlag_q
);
    // Slack on the long retry wait for sync and reload
    localparam int LMAX = RETRY_LONG_CYC + 6;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic rdReq = accStrobe && !accWrite;
    ////////////////////////////////////////
    // Register port answers
    property p_rd_ans; rdReq |=> rdValid_q; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_rd_one; !rdReq |=> !rdValid_q; endproperty
    a_rd_one: assert property (p_rd_one) else $error("read valid without read");
    property p_unmap;
        rdReq && accAddr != 6'h11 && accAddr != 6'h12 && accAddr != 6'h3f |=> rdData_q == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_cfg;
        rdReq && accAddr == 6'h3f |=> rdData_q[15:7] == 9'h000 && rdData_q[2:0] == 3'h0;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config read spare bits set");
    // Driver gating on overcurrent
    property p_oc_off; $rose(overcurrentDet[0]) && driverOn[0] |-> ##3 !driverOn[0]; endproperty
    a_oc_off: assert property (p_oc_off) else $error("driver not cut off");
    property p_manual;
        $fell(driverOn[15]) && outEnable[15] && !recoveryEnable[15]
            ##1 (!(accStrobe && accClear)) [*8] |-> !driverOn[15];
    endproperty
    a_manual: assert property (p_manual) else $error("driver back without clear");
    property p_short;
        $fell(driverOn[0]) && outEnable[0] && recoveryEnable[0] && retryDutySel
            |-> (!driverOn[0]) [*4] ##[1:4] driverOn[0];
    endproperty
    a_short: assert property (p_short) else $error("short retry timing wrong");
    property p_long;
        $fell(driverOn[0]) && outEnable[0] && recoveryEnable[0] && !retryDutySel
            |-> (!driverOn[0]) [*8] ##[1:LMAX] driverOn[0];
    endproperty
    a_long: assert property (p_long) else $error("long retry timing wrong");
    c_clear: cover property (rdReq && accClear);
    c_retry: cover property ($rose(driverOn[0]) && recoveryEnable[0]);
    c_summary: cover property ($rose(warnOpenSummary_q));
endmodule // ofs_status_bank_sva
bind ofs_status_bank ofs_status_bank_sva #(.OL_FILTER_CYC(OL_FILTER_CYC),
    .RETRY_LONG_CYC(RETRY_LONG_CYC), .RETRY_SHORT_CYC(RETRY_SHORT_CYC)) chk (.*);
`default_nettype wire

/* File: ofs_host_model.sv */
// Host side of the access port: read, read-and-clear, write.
// Assumes requests launch on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module ofs_host_model (
    input wire logic        clk,
    input wire logic [15:0] rdData_q,
    output logic            accStrobe = 1'b0,
    output logic            accWrite = 1'b0,
    output logic            accClear = 1'b0,
    output logic [5:0]      accAddr = 6'h00,
    output logic [15:0]     accWrData = 16'h0000
);
    ////////////////////////////////////////
    // One-cycle strobe; idle address and data inverted so no stale value passes
    task automatic acc(input logic [5:0] a, input logic w, input logic c,
        input logic [15:0] wd, output logic [15:0] d);
        @(negedge clk);
        accStrobe = 1'b1;
        accWrite = w;
        accClear = c;
        accAddr = a;
        accWrData = wd;
        @(negedge clk);
        d = rdData_q;
        accStrobe = 1'b0;
        accAddr = ~a;
        accWrData = ~wd;
    endtask
endmodule // ofs_host_model
`default_nettype wire

/* File: ofs_status_bank_tb.sv */
// Self-checking bench for the status bank.
// Assumes the host model drives the access port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin nCompared++; if ((a) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module ofs_status_bank_tb;
    logic        clk, sys_rst, rdValid_q, retryDutySel, tempWarnDet;
    logic        accStrobe, accWrite, accClear, warnOpenSummary_q, globalErrorFlag_q;
    logic [5:0]  accAddr;
    logic [15:0] accWrData, rdData_q, recoveryEnable, outEnable, overcurrentDet;
    logic [15:0] underCurrentDet, driverOn, rd;
    int          failures = 0, nCompared = 0;
    int          st[5] = '{0, 1, 11, 14, 15};
    int          mb[5] = '{4, 5, 6, 6, 6};
    ofs_status_bank #(.OL_FILTER_CYC(18'd20), .RETRY_LONG_CYC(18'd10),
        .RETRY_SHORT_CYC(18'd4)) uut (.*);
    ofs_host_model h (.*);
    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chkRd(input logic [5:0] a, input logic c, input logic [15:0] e);
        h.acc(a, 1'b0, c, 16'h0000, rd);
        `CHK("readData", e, rd)
    endtask
    task automatic close_out;
        if (failures == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog well past the few hundred cycles needed
    initial
    begin
        #200000;
        failures++;
        close_out;
    end
    initial
    begin
        sys_rst = 1'b1;
        {recoveryEnable, overcurrentDet, underCurrentDet} = 48'h0;
        {retryDutySel, tempWarnDet} = 2'b00;
        outEnable = 16'hffff;
        cyc(8);
        sys_rst = 1'b0;
        cyc(4);
        h.acc(6'h11, 1'b1, 1'b0, 16'hffff, rd);
        chkRd(6'h11, 1'b0, 16'h0000);
        chkRd(6'h12, 1'b0, 16'h0000);
        chkRd(6'h20, 1'b0, 16'h0000);
        // Manual restart on the fast discharge stage
        overcurrentDet = 16'h8000;
        cyc(4);
        overcurrentDet = 16'h0000;
        cyc(10);
        `CHK("drvOff", 16'h7fff, driverOn)
        chkRd(6'h11, 1'b1, 16'h8000);
        cyc(3);
        `CHK("drvBack", 16'hffff, driverOn)
        chkRd(6'h11, 1'b0, 16'h0000);
        // Auto retry, long then short off time
        recoveryEnable = 16'h0001;
        for (int d = 0; d < 2; d++)
        begin
            retryDutySel = d[0];
            overcurrentDet = 16'h0001;
            cyc(3);
            overcurrentDet = 16'h0000;
            cyc(2);
            `CHK("retryOff", 1'b0, driverOn[0])
            cyc(25);
            `CHK("retryOn", 1'b1, driverOn[0])
            chkRd(6'h11, 1'b1, 16'h0001);
        end
        // Brief activation; a break restarts the filter
        recoveryEnable = 16'h0000;
        underCurrentDet = 16'h0002;
        cyc(15);
        underCurrentDet = 16'h0000;
        cyc(2);
        underCurrentDet = 16'h0002;
        cyc(15);
        chkRd(6'h12, 1'b0, 16'h0000);
        cyc(10);
        chkRd(6'h12, 1'b0, 16'h0002);
        underCurrentDet = 16'h0000;
        cyc(3);
        chkRd(6'h12, 1'b1, 16'h0002);
        // Idle stage neither drives nor collects open load
        outEnable = 16'hfffd;
        underCurrentDet = 16'h0002;
        cyc(25);
        `CHK("drvIdle", 16'hfffd, driverOn)
        chkRd(6'h12, 1'b1, 16'h0000);
        underCurrentDet = 16'h0000;
        outEnable = 16'hffff;
        cyc(3);
        // Masks hide stages from the summary but not the flags
        for (int i = 0; i < 5; i++)
        begin
            underCurrentDet = 16'h0001 << st[i];
            cyc(25);
            underCurrentDet = 16'h0000;
            cyc(3);
            `CHK("summary", 1'b1, warnOpenSummary_q)
            `CHK("globalErr", 1'b1, globalErrorFlag_q)
            h.acc(6'h3f, 1'b1, 1'b0, 16'h0001 << mb[i], rd);
            cyc(3);
            `CHK("masked", 1'b0, warnOpenSummary_q)
            `CHK("maskedErr", 1'b0, globalErrorFlag_q)
            chkRd(6'h3f, 1'b0, 16'h0001 << mb[i]);
            chkRd(6'h12, 1'b1, 16'h0001 << st[i]);
            h.acc(6'h3f, 1'b1, 1'b0, 16'h0000, rd);
        end
        // Temperature warning alone, then kept off the error flag by bit 3
        tempWarnDet = 1'b1;
        cyc(4);
        `CHK("warnSum", 1'b1, warnOpenSummary_q)
        `CHK("warnErr", 1'b1, globalErrorFlag_q)
        h.acc(6'h3f, 1'b1, 1'b0, 16'h0008, rd);
        cyc(2);
        `CHK("errGated", 1'b0, globalErrorFlag_q)
        `CHK("sumKept", 1'b1, warnOpenSummary_q)
        chkRd(6'h3f, 1'b0, 16'h0008);
        h.acc(6'h3f, 1'b1, 1'b0, 16'h0000, rd);
        tempWarnDet = 1'b0;
        close_out;
    end
endmodule // ofs_status_bank_tb
`default_nettype wire
